// ===== rtl/sww_regs.vh
`ifndef SWW_REGS_VH
`define SWW_REGS_VH
// Timing figures in microseconds, filter lengths in clock cycles, clock in MHz
`define SWW_CLK_MHZ          100
`define SWW_RST_STRETCH_US   1000
`define SWW_NREQ_TIMEOUT_US  150000
`define SWW_WD_FALLBACK_US   150000
`define SWW_GLITCH_CYC       16
`define SWW_BUS_FILT_CYC     3000
// Operating state select encodings
`define SWW_MODE_NORMAL      2'h0
`define SWW_MODE_SLEEP       2'h1
`define SWW_MODE_STOP        2'h2
// Watchdog config pin codes
`define SWW_WDCFG_RES        2'h0
`define SWW_WDCFG_GND        2'h1
`define SWW_WDCFG_OPEN       2'h2
// Wake source bit positions and field width
`define SWW_WK_IN1           0
`define SWW_WK_IN2           1
`define SWW_WK_BUS           2
`define SWW_WK_TIMER         3
`define SWW_WK_W             4
`endif

// ===== rtl/sww_sync.v
`timescale 1ns/1ps
`default_nettype none
module sww_sync #(
  parameter W = 1
) (
  input  wire         mclk_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
    end else begin
      s1 <= d_i;
      s2 <= s1;
    end
  end
  assign q_o = s2;
endmodule
`default_nettype wire

// ===== rtl/sww_top.v
// Functional notes
// - Reset output low while a low supply or overtemperature cause persists, then stretched at least 1 ms.
// - Regulated supply below reset threshold issues a reset, except in Sleep.
// - Regulator overtemperature disables regulator and sets its flag.
// - Watchdog expiry without valid clear resets the host.
// - Clear by mode write; early clear resets like overflow.
// - Config pin sampled in Reset; grounded disables watchdog, skips Normal Request on exit from Reset.
// - Open config pin uses 150 ms fallback timebase and reports fault.
// - Watchdog timebase shifted left by prescaler from timing control register.
// - Normal Request times out after 150 ms into Reset, then back.
// - Host holding reset pin low past filter sends device to Reset outside Sleep and Stop, again after each stretch ends.
// - Sleep wake re-enables regulator and resets host.
// - Stop wake raises interrupt; wake cause readable in both low modes.
// - Chip select rising edge wakes Stop, no interrupt, no source bit.
// - Reset pin low in Stop wakes to Normal Request or Normal, unreported.
// - Per-input wake enables; current input states shown in status.
// - Input selected in analog mux at low-power entry cannot wake.
// - Cyclic sense pulses switch; wake at period end on input change.
// - Forced wake with switch off wakes after period; exclusive with sense.
// - Bus wake needs long dominant then recessive; stuck dominant ignored.
// - Bus faults except overcurrent disable driver until gone and read.
// - Switch enable and PWM select: switch follows PWM input pin.
// - Interrupt output active low, held until host acknowledges by read.
// - Interrupt output never asserted while device drives reset line or host holds it low past filter.
`timescale 1ns/1ps
`default_nettype none
`include "sww_regs.vh"
module sww_top #(
  parameter RST_CYC  = `SWW_RST_STRETCH_US * `SWW_CLK_MHZ,
  parameter NREQ_CYC = `SWW_NREQ_TIMEOUT_US * `SWW_CLK_MHZ,
  parameter WDFB_CYC = `SWW_WD_FALLBACK_US * `SWW_CLK_MHZ,
  parameter SENSE_UNIT_CYC = 100000
) (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       vdd_low_i,
  input  wire       reg_overtemp_i,
  input  wire [1:0] watchdog_config_pin_i,
  input  wire [15:0] wd_res_period_i,
  input  wire       rst_pin_i,
  output wire       rst_pin_o,
  output wire       rst_pin_oe_o,
  output wire       irq_n_o,
  input  wire       mode_wr_i,
  input  wire [1:0] operating_state_select_bits_i,
  input  wire [2:0] timing_prescale_i,
  input  wire       sense_or_watchdog_select_i,
  input  wire [1:0] sense_period_select_i,
  input  wire [1:0] input_wake_enable_i,
  input  wire [1:0] mux_select_input_i,
  input  wire       high_side_switch_i,
  input  wire       high_side_pwm_select_i,
  input  wire       pwm_input_pin_i,
  input  wire       wake_input_one_i,
  input  wire       wake_input_two_i,
  input  wire       cs_n_i,
  input  wire       bus_rx_i,
  input  wire       bus_overtemp_i,
  input  wire       bus_tx_dom_i,
  input  wire       bus_rx_short_i,
  input  wire       bus_overcurrent_i,
  input  wire       bus_status_rd_i,
  input  wire       irq_ack_rd_i,
  output reg        regulator_en_o,
  output reg        regulator_overtemp_flag_o,
  output reg        watchdog_off_flag_o,
  output reg        watchdog_fallback_flag_o,
  output reg  [1:0] wakeup_status_reg_o,
  output reg  [3:0] wake_source_o,
  output reg        bus_driver_en_o,
  output reg  [3:0] bus_status_reg_o,
  output reg        high_side_on_o,
  output reg  [5:0] state_o
);
  localparam S_RESET = 6'h01;
  localparam S_NREQ  = 6'h02;
  localparam S_NORM  = 6'h04;
  localparam S_SLEEP = 6'h08;
  localparam S_STOP  = 6'h10;
  localparam S_SPARE = 6'h20;

  wire [8:0] sy;
  sww_sync #(.W(9)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({pwm_input_pin_i, bus_rx_i, cs_n_i, wake_input_two_i, wake_input_one_i,
                rst_pin_i, watchdog_config_pin_i, vdd_low_i}),
    .q_o     (sy)
  );
  wire       vdd_low = sy[0];
  wire [1:0] wdcfg   = sy[2:1];
  wire       rpin    = sy[3];
  wire [1:0] lin     = sy[5:4];
  wire       cs_n    = sy[6];
  wire       rx      = sy[7];
  wire       pwm     = sy[8];

  function [31:0] sense_cyc;
    input [1:0] sel;
    begin
      sense_cyc = SENSE_UNIT_CYC * ({30'h0, sel} + 32'h1);
    end
  endfunction

  reg [5:0]  state;
  reg [31:0] rcnt;
  reg [31:0] tcnt;
  reg [31:0] scnt;
  reg [15:0] gcnt;
  reg [15:0] bcnt;
  reg        rpin_low;
  reg        cs_q;
  reg        rx_q;
  reg        bus_long;
  reg        wd_off;
  reg [1:0]  lin_ref;
  reg [1:0]  wake_mask;
  reg        sense_en;
  reg        forced_en;
  reg        irq_pend;
  reg        host_rst;
  reg        wd_fail;
  wire       own_rst_pin = (state == S_RESET);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gcnt     <= 16'h0;
      rpin_low <= 1'b0;
    end else if (rpin || own_rst_pin) begin
      gcnt     <= 16'h0;
      rpin_low <= 1'b0;
    end else if (gcnt >= `SWW_GLITCH_CYC) begin
      rpin_low <= 1'b1;
    end else begin
      gcnt <= gcnt + 16'h1;
    end
  end

  // Bus wake filter
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bcnt     <= 16'h0;
      bus_long <= 1'b0;
      rx_q     <= 1'b1;
      cs_q     <= 1'b1;
    end else begin
      rx_q <= rx;
      cs_q <= cs_n;
      if (rx) begin
        bcnt <= 16'h0;
      end else if (bcnt >= `SWW_BUS_FILT_CYC) begin
        bus_long <= 1'b1;
      end else begin
        bcnt <= bcnt + 16'h1;
      end
      if (rx && !rx_q) begin
        bus_long <= 1'b0;
      end
    end
  end
  wire bus_wake = rx && !rx_q && bus_long;
  wire cs_rise  = cs_n && !cs_q;

  wire [31:0] wd_base  = (wdcfg == `SWW_WDCFG_OPEN) ? WDFB_CYC :
                         ({16'h0, wd_res_period_i} * `SWW_CLK_MHZ);
  wire [31:0] wd_to    = wd_base << timing_prescale_i;
  wire        wd_clear = mode_wr_i && (operating_state_select_bits_i == `SWW_MODE_NORMAL);
  wire [1:0]  lin_chg  = (lin ^ lin_ref) & input_wake_enable_i & ~wake_mask;
  wire        period_end = (scnt >= sense_cyc(sense_period_select_i));
  wire        lowpwr   = (state == S_SLEEP) || (state == S_STOP);
  wire        direct_wk = lowpwr && !sense_en && (lin_chg != 2'h0);
  wire        sense_wk  = lowpwr && sense_en && period_end && (lin_chg != 2'h0);
  wire        forced_wk = lowpwr && forced_en && period_end;
  wire        any_wk    = direct_wk || sense_wk || forced_wk || (lowpwr && bus_wake);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= S_RESET;
      rcnt      <= 32'h0;
      tcnt      <= 32'h0;
      scnt      <= 32'h0;
      wd_off    <= 1'b0;
      watchdog_off_flag_o      <= 1'b0;
      watchdog_fallback_flag_o <= 1'b0;
      lin_ref   <= 2'h0;
      wake_mask <= 2'h0;
      sense_en  <= 1'b0;
      forced_en <= 1'b0;
      wake_source_o <= 4'h0;
      irq_pend  <= 1'b0;
      wd_fail   <= 1'b0;
    end else begin
      wd_fail <= 1'b0;
      if (irq_ack_rd_i) begin
        wake_source_o <= 4'h0;
        irq_pend      <= 1'b0;
      end
      case (state)
        S_RESET: begin
          tcnt <= 32'h0;
          wd_off <= (wdcfg == `SWW_WDCFG_GND);
          watchdog_off_flag_o      <= (wdcfg == `SWW_WDCFG_GND);
          watchdog_fallback_flag_o <= (wdcfg == `SWW_WDCFG_OPEN);
          if (host_rst) begin
            rcnt <= 32'h0;
          end else if (rcnt >= RST_CYC - 1) begin
            rcnt  <= 32'h0;
            state <= (wdcfg == `SWW_WDCFG_GND) ? S_NORM : S_NREQ;
          end else begin
            rcnt <= rcnt + 32'h1;
          end
        end
        S_NREQ: begin
          if (tcnt >= NREQ_CYC - 1) begin
            state <= S_RESET;
          end else if (wd_clear) begin
            state <= S_NORM;
            tcnt  <= 32'h0;
          end else begin
            tcnt <= tcnt + 32'h1;
          end
        end
        S_NORM: begin
          if (mode_wr_i && (operating_state_select_bits_i == `SWW_MODE_SLEEP ||
                            operating_state_select_bits_i == `SWW_MODE_STOP)) begin
            state     <= (operating_state_select_bits_i == `SWW_MODE_SLEEP) ? S_SLEEP : S_STOP;
            lin_ref   <= lin;
            wake_mask <= mux_select_input_i;
            sense_en  <= sense_or_watchdog_select_i && high_side_switch_i;
            forced_en <= sense_or_watchdog_select_i && !high_side_switch_i;
            scnt      <= 32'h0;
            tcnt      <= 32'h0;
          end else if (!wd_off) begin
            if (wd_clear && (tcnt < (wd_to >> 1))) begin
              wd_fail <= 1'b1;
              state   <= S_RESET;
            end else if (wd_clear) begin
              tcnt <= 32'h0;
            end else if (tcnt >= wd_to - 32'h1) begin
              wd_fail <= 1'b1;
              state   <= S_RESET;
            end else begin
              tcnt <= tcnt + 32'h1;
            end
          end
        end
        S_SLEEP, S_STOP: begin
          scnt <= period_end ? 32'h0 : scnt + 32'h1;
          if (period_end) begin
            lin_ref <= lin;
          end
          if (any_wk) begin
            wake_source_o <= wake_source_o |
                             {forced_wk, lowpwr && bus_wake, lin_chg[1], lin_chg[0]};
            state <= (state == S_SLEEP) ? S_RESET : S_NREQ;
            if (state == S_STOP) begin
              irq_pend <= 1'b1;
            end
          end else if (state == S_STOP && cs_rise) begin
            state <= S_NREQ;
          end else if (state == S_STOP && rpin_low) begin
            state <= wd_off ? S_NORM : S_NREQ;
          end
        end
        default: begin
          state <= S_RESET;
        end
      endcase
      if (rpin_low && !lowpwr) begin
        state <= S_RESET;
      end
      if ((vdd_low || reg_overtemp_i) && state != S_SLEEP) begin
        state <= S_RESET;
      end
    end
  end

  always @* begin
    host_rst = vdd_low || reg_overtemp_i || rpin_low;
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_en_o            <= 1'b1;
      regulator_overtemp_flag_o <= 1'b0;
      wakeup_status_reg_o       <= 2'h0;
      bus_driver_en_o           <= 1'b0;
      bus_status_reg_o          <= 4'h0;
      high_side_on_o            <= 1'b0;
      state_o                   <= S_RESET;
    end else begin
      state_o             <= state;
      wakeup_status_reg_o <= lin;
      regulator_en_o <= !reg_overtemp_i && (state != S_SLEEP);
      if (reg_overtemp_i) begin
        regulator_overtemp_flag_o <= 1'b1;
      end
      bus_status_reg_o <= (bus_status_reg_i_clear(bus_status_rd_i, bus_status_reg_o)) |
                          {bus_overcurrent_i, bus_rx_short_i, bus_tx_dom_i, bus_overtemp_i};
      bus_driver_en_o <= (state == S_NORM) && (bus_status_reg_o[2:0] == 3'h0) &&
                         !bus_overtemp_i && !bus_tx_dom_i && !bus_rx_short_i;
      if (lowpwr) begin
        high_side_on_o <= sense_en && period_end;
      end else if (state == S_NREQ || state == S_NORM) begin
        high_side_on_o <= high_side_switch_i && (!high_side_pwm_select_i || pwm);
      end else begin
        high_side_on_o <= 1'b0;
      end
    end
  end

  function [3:0] bus_status_reg_i_clear;
    input       rd;
    input [3:0] cur;
    begin
      bus_status_reg_i_clear = rd ? 4'h0 : cur;
    end
  endfunction

  // Reset pin drive
  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe_o = own_rst_pin;
  assign irq_n_o = !(irq_pend && !own_rst_pin && !rpin_low);
endmodule
`default_nettype wire

// ===== bench/sww_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sww_chk #(
  parameter RST_CYC  = 10,
  parameter NREQ_CYC = 50
) (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       vdd_low_i,
  input wire logic       reg_overtemp_i,
  input wire logic       pwm_input_pin_i,
  input wire logic       high_side_switch_i,
  input wire logic       high_side_pwm_select_i,
  input wire logic       bus_overtemp_i,
  input wire logic       bus_overcurrent_i,
  input wire logic       irq_ack_rd_i,
  input wire logic       rst_pin_oe_o,
  input wire logic       irq_n_o,
  input wire logic       regulator_en_o,
  input wire logic       regulator_overtemp_flag_o,
  input wire logic       watchdog_off_flag_o,
  input wire logic       bus_driver_en_o,
  input wire logic [3:0] bus_status_reg_o,
  input wire logic       high_side_on_o,
  input wire logic [5:0] state_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] oe_cnt;
  logic [31:0] nreq_cnt;
  // Run lengths of reset drive and Normal Request
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_cnt <= 32'h0;
      nreq_cnt <= 32'h0;
    end else begin
      oe_cnt <= rst_pin_oe_o ? oe_cnt + 32'h1 : 32'h0;
      nreq_cnt <= state_o[1] ? nreq_cnt + 32'h1 : 32'h0;
    end
  end
  reset_stretch_a: assert property ($fell(rst_pin_oe_o) |-> oe_cnt >= RST_CYC - 1)
    else $error("reset released too early");
  vdd_reset_a: assert property (vdd_low_i [*6] |-> rst_pin_oe_o || state_o[3])
    else $error("low supply without reset");
  reg_overtemp_a: assert property (reg_overtemp_i |-> ##[1:3]
    (!regulator_en_o && regulator_overtemp_flag_o)) else $error("regulator not shut down");
  skip_nreq_a: assert property ($fell(state_o[0]) |->
    state_o == (watchdog_off_flag_o ? 6'h04 : 6'h02)) else $error("wrong state after reset");
  nreq_timeout_a: assert property (nreq_cnt <= NREQ_CYC + 4)
    else $error("normal request overstayed");
  bus_fault_a: assert property (bus_overtemp_i [*4] |-> !bus_driver_en_o)
    else $error("bus driver on during fault");
  overcurrent_flag_a: assert property (bus_overcurrent_i [*3] |-> bus_status_reg_o[3])
    else $error("overcurrent flag missing");
  pwm_follow_a: assert property ((state_o == 6'h04 && high_side_switch_i
    && high_side_pwm_select_i && $stable(pwm_input_pin_i)) [*6] |-> high_side_on_o == pwm_input_pin_i)
    else $error("switch not following pwm");
  irq_hold_a: assert property (!irq_n_o && !irq_ack_rd_i |=> !irq_n_o || rst_pin_oe_o)
    else $error("interrupt dropped without read");
  irq_in_reset_a: assert property (rst_pin_oe_o |-> irq_n_o)
    else $error("interrupt during reset");
  cover property ($fell(irq_n_o));
  cover property ($rose(state_o[4]));
  cover property ($fell(bus_driver_en_o));
endmodule
bind sww_top sww_chk #(.RST_CYC(RST_CYC), .NREQ_CYC(NREQ_CYC)) sww_chk_i (.mclk_i, .rst_n_i,
  .vdd_low_i, .reg_overtemp_i, .pwm_input_pin_i, .high_side_switch_i, .high_side_pwm_select_i,
  .bus_overtemp_i, .bus_overcurrent_i, .irq_ack_rd_i, .rst_pin_oe_o, .irq_n_o, .regulator_en_o,
  .regulator_overtemp_flag_o, .watchdog_off_flag_o, .bus_driver_en_o, .bus_status_reg_o,
  .high_side_on_o, .state_o);
`default_nettype wire

// ===== bench/sww_host.sv
`timescale 1ns/1ps
`default_nettype none
module sww_host (
  input  wire logic mclk_i,
  input  wire logic irq_n_i,
  input  wire logic dev_oe_i,
  input  wire logic hold_i,
  output wire logic rst_pin_o,
  output var  logic irq_ack_rd_o
);
  logic [2:0] wait_cnt;
  initial begin
    wait_cnt = 3'h0;
    irq_ack_rd_o = 1'b0;
  end
  assign rst_pin_o = !(dev_oe_i || hold_i);
  always @(posedge mclk_i) begin
    wait_cnt <= (irq_n_i || irq_ack_rd_o) ? 3'h0 : wait_cnt + 3'h1;
    irq_ack_rd_o <= (wait_cnt == 3'h3);
  end
endmodule
`default_nettype wire

// ===== bench/test_supervisor_wake_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "sww_regs.vh"
module test_supervisor_wake_watchdog;
  localparam RST_CYC = 10;
  localparam NREQ_CYC = 50;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, vdd_low_i, reg_overtemp_i, mode_wr_i, hold, cs_n_i, bus_rx_i;
  logic sense_or_watchdog_select_i, high_side_switch_i, high_side_pwm_select_i, pwm_input_pin_i;
  logic wake_input_one_i, wake_input_two_i, bus_overtemp_i, bus_tx_dom_i, bus_rx_short_i;
  logic bus_overcurrent_i, bus_status_rd_i;
  logic [1:0] watchdog_config_pin_i, operating_state_select_bits_i, sense_period_select_i;
  logic [1:0] input_wake_enable_i, mux_select_input_i;
  logic [2:0] timing_prescale_i;
  logic [15:0] wd_res_period_i;
  wire logic rst_pin_i, rst_pin_o, rst_pin_oe_o, irq_n_o, irq_ack_rd_i, regulator_en_o;
  wire logic regulator_overtemp_flag_o, watchdog_off_flag_o, watchdog_fallback_flag_o;
  wire logic bus_driver_en_o, high_side_on_o;
  wire logic [1:0] wakeup_status_reg_o;
  wire logic [3:0] wake_source_o, bus_status_reg_o;
  wire logic [5:0] state_o;
  int num_errors = 0, compares = 0, cycles = 0, n, i;
  logic [31:0] seed = 32'haf78;
  sww_top #(.RST_CYC(RST_CYC), .NREQ_CYC(NREQ_CYC), .WDFB_CYC(100), .SENSE_UNIT_CYC(20))
  sww_top_i (.mclk_i, .rst_n_i, .vdd_low_i, .reg_overtemp_i, .watchdog_config_pin_i,
    .wd_res_period_i, .rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .irq_n_o, .mode_wr_i,
    .operating_state_select_bits_i, .timing_prescale_i, .sense_or_watchdog_select_i,
    .sense_period_select_i, .input_wake_enable_i, .mux_select_input_i, .high_side_switch_i,
    .high_side_pwm_select_i, .pwm_input_pin_i, .wake_input_one_i, .wake_input_two_i, .cs_n_i,
    .bus_rx_i, .bus_overtemp_i, .bus_tx_dom_i, .bus_rx_short_i, .bus_overcurrent_i,
    .bus_status_rd_i, .irq_ack_rd_i, .regulator_en_o, .regulator_overtemp_flag_o,
    .watchdog_off_flag_o, .watchdog_fallback_flag_o, .wakeup_status_reg_o, .wake_source_o,
    .bus_driver_en_o, .bus_status_reg_o, .high_side_on_o, .state_o);
  sww_host sww_host_i (.mclk_i(mclk_i), .irq_n_i(irq_n_o), .dev_oe_i(rst_pin_oe_o),
    .hold_i(hold), .rst_pin_o(rst_pin_i), .irq_ack_rd_o(irq_ack_rd_i));
  always #5 mclk_i = ~mclk_i;
  task automatic final_report;
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      final_report;
    end
  end
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic ticks(input int c);
    repeat (c) @(negedge mclk_i);
  endtask
  task automatic wait_st(input logic [5:0] s, input int c);
    for (int k = 0; k < c && state_o !== s; k++) ticks(1);
    chk(state_o === s, "state");
  endtask
  task automatic wait_irq(input logic v, input int c);
    for (int k = 0; k < c && irq_n_o !== v; k++) ticks(1);
    chk(irq_n_o === v, "irq level");
  endtask
  task automatic wr_mode(input logic [1:0] m);
    ticks(1);
    operating_state_select_bits_i = m;
    mode_wr_i = 1'b1;
    ticks(1);
    mode_wr_i = 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] cfg);
    watchdog_config_pin_i = cfg;
    ticks(1);
    rst_n_i = 1'b0;
    ticks(2);
    rst_n_i = 1'b1;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic exp_hs(input logic [2:0] v);
    return v[2] && (!v[1] || v[0]);
  endfunction
  initial begin
    {vdd_low_i, reg_overtemp_i, mode_wr_i, hold, sense_or_watchdog_select_i, high_side_switch_i,
      high_side_pwm_select_i, pwm_input_pin_i, wake_input_one_i, wake_input_two_i,
      bus_overtemp_i, bus_tx_dom_i, bus_rx_short_i, bus_overcurrent_i, bus_status_rd_i,
      operating_state_select_bits_i, sense_period_select_i, mux_select_input_i,
      timing_prescale_i, watchdog_config_pin_i} = '0;
    {cs_n_i, bus_rx_i, input_wake_enable_i} = 4'hf;
    wd_res_period_i = 16'h0064;
    do_reset(`SWW_WDCFG_RES);
    for (n = 0; n < 100 && rst_pin_oe_o === 1'b1; n++) ticks(1);
    chk(n >= RST_CYC - 1, "stretch");
    wait_st(6'h02, 5);
    wait_st(6'h01, NREQ_CYC + 10);
    wait_st(6'h02, RST_CYC + 10);
    wr_mode(`SWW_MODE_NORMAL);
    wait_st(6'h04, 4);
    wr_mode(`SWW_MODE_NORMAL);
    wait_st(6'h01, 8);
    do_reset(`SWW_WDCFG_OPEN);
    ticks(RST_CYC + 4);
    chk(watchdog_fallback_flag_o === 1'b1 && watchdog_off_flag_o === 1'b0, "fallback");
    $display("test watchdog modes done");
    do_reset(`SWW_WDCFG_GND);
    wait_st(6'h04, RST_CYC + 10);
    chk(watchdog_off_flag_o === 1'b1, "wd off");
    hold = 1'b1;
    wait_st(6'h01, 30);
    chk(rst_pin_i === 1'b0, "held reset");
    hold = 1'b0;
    wait_st(6'h04, RST_CYC + 30);
    wr_mode(`SWW_MODE_STOP);
    wait_st(6'h10, 4);
    wake_input_one_i = 1'b1;
    wait_irq(1'b0, 40);
    chk(wake_source_o[`SWW_WK_IN1] === 1'b1, "source");
    wait_irq(1'b1, 12);
    chk(wakeup_status_reg_o === 2'b01, "input state");
    wr_mode(`SWW_MODE_NORMAL);
    mux_select_input_i = 2'b10;
    wr_mode(`SWW_MODE_STOP);
    wait_st(6'h10, 4);
    wake_input_two_i = 1'b1;
    ticks(40);
    chk(state_o === 6'h10, "muxed input woke");
    cs_n_i = 1'b0;
    ticks(3);
    cs_n_i = 1'b1;
    ticks(20);
    chk(state_o !== 6'h10 && irq_n_o === 1'b1 && wake_source_o === 4'h0, "cs wake");
    mux_select_input_i = 2'b00;
    wr_mode(`SWW_MODE_NORMAL);
    wr_mode(`SWW_MODE_SLEEP);
    wait_st(6'h08, 4);
    wake_input_one_i = 1'b0;
    wait_st(6'h01, 40);
    chk(regulator_en_o === 1'b1 && wake_source_o[`SWW_WK_IN1] === 1'b1, "sleep wake");
    wait_st(6'h04, RST_CYC + 10);
    {sense_or_watchdog_select_i, high_side_switch_i, sense_period_select_i} = 4'b1000;
    wr_mode(`SWW_MODE_STOP);
    wait_irq(1'b0, 60);
    chk(wake_source_o[`SWW_WK_TIMER] === 1'b1, "forced wake");
    sense_or_watchdog_select_i = 1'b0;
    wait_st(6'h02, 12);
    wr_mode(`SWW_MODE_NORMAL);
    wait_st(6'h04, 6);
    $display("test wake done");
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      {high_side_switch_i, high_side_pwm_select_i, pwm_input_pin_i} = seed[2:0];
      ticks(6);
      chk(high_side_on_o === exp_hs(seed[2:0]), "switch");
    end
    for (i = 0; i < 3; i++) begin
      {bus_rx_short_i, bus_tx_dom_i, bus_overtemp_i} = 3'b001 << i;
      ticks(4);
      chk(bus_driver_en_o === 1'b0, "fault");
      {bus_rx_short_i, bus_tx_dom_i, bus_overtemp_i} = 3'b000;
      ticks(3);
      bus_status_rd_i = 1'b1;
      ticks(1);
      bus_status_rd_i = 1'b0;
      ticks(3);
      chk(bus_driver_en_o === 1'b1, "restart");
    end
    bus_overcurrent_i = 1'b1;
    ticks(4);
    chk(bus_driver_en_o === 1'b1 && bus_status_reg_o[3] === 1'b1, "overcurrent");
    vdd_low_i = 1'b1;
    ticks(6);
    chk(rst_pin_oe_o === 1'b1, "low supply");
    vdd_low_i = 1'b0;
    wait_st(6'h04, RST_CYC + 20);
    reg_overtemp_i = 1'b1;
    ticks(3);
    chk(regulator_en_o === 1'b0 && regulator_overtemp_flag_o === 1'b1, "overtemp");
    $display("test faults done");
    final_report;
  end
endmodule
`default_nettype wire
